//--- bench/tb.sv
// self-checking bench of the tx input/error block
`timescale 1ns/1ps
`include "txpie_regs.vh"
module tb;
  localparam ST = 15;
  localparam RL = 64;
  reg         clk = 1'h0;
  reg         rst = 1'h1;
  reg  [3:0]  addr = 4'h0;
  reg         rd = 1'h0;
  reg         wr = 1'h0;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  be = 4'h0;
  wire [31:0] rdata;
  wire        waitreq;
  wire        irq;
  wire [19:0] chars;
  wire [1:0]  hclk;
  reg  [1:0]  refclk = 2'h0;
  reg  [1:0]  ref_run = 2'h3;
  reg  [1:0]  host_run = 2'h3;
  reg  [9:0]  start = 10'h0;
  wire [1:0]  flag;
  wire [19:0] cout;
  wire [1:0]  strobe;
  reg  [15:0] cw = 16'h1e1e;
  reg  [31:0] seed = 32'h13;
  reg  [31:0] got;
  reg  [9:0]  prev;
  reg         have_prev = 1'h0;
  reg         data_chk = 1'h0;
  integer     miscompares = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     k;
  integer     n1;
  integer     n2;

  txpie_top #(.REF_LOSS(RL), .ST_LEN(ST)) DUT (
    .core_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq),
    .tx_char_in_i(chars), .tx_host_char_clock_i(hclk),
    .channel_reference_clock_i(refclk), .tx_error_flag_o(flag),
    .tx_char_out_o(cout), .tx_char_strobe_o(strobe)
  );
  txpie_host u_host (.run_i(host_run), .start_i(start), .host_clk_o(hclk), .chars_o(chars));

  // core clock, and reference clocks offset from it that stand low when stopped
  always #10 clk = ~clk;
  initial begin
    #3;
    forever begin
      #80;
      refclk = ref_run & ~refclk;
    end
  end

  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] act);
    begin
      n_tests = n_tests + 1;
      if (act !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h got %h", name, exp, act);
      end
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input we, input [3:0] a, input [31:0] d, input [3:0] b);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= !we;
      wr <= we;
      @(posedge clk);
      while (waitreq !== 1'h0) @(posedge clk);
      got = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
    end
  endtask

  task rdc(input [8*8-1:0] name, input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'h0, a, 32'h0, 4'hf);
      chk(name, e, got & m);
    end
  endtask

  task setc;
    bus(1'h1, `TXPIE_CTRL_OFS, {16'h0, cw}, 4'h3);
  endtask

  // writing 0 to the re-centre latch of the lanes enabled
  task recenter(input [3:0] b);
    begin
      bus(1'h1, `TXPIE_CTRL_OFS, {16'h0, cw & 16'hfdfd}, b);
      repeat (60) @(posedge clk);
    end
  endtask

  task waitf(input integer c, input v, output integer n);
    begin
      n = 0;
      while (flag[c] !== v && n < 400) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask

  task print_verdict;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // channel 0 characters leave one after another; timeout guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (strobe[0] === 1'h1 && data_chk) begin
      if (have_prev) chk("char", {22'h0, prev + 10'h001}, {22'h0, cout[9:0]});
      prev <= cout[9:0];
      have_prev <= 1'h1;
    end else if (!data_chk) have_prev <= 1'h0;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end

  initial begin
    seed = xs(seed);
    start = seed[9:0];
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdc("ctrl", `TXPIE_CTRL_OFS, 32'hffffffff, 32'h1e1e);
    rdc("mask", `TXPIE_INT_MASK_OFS, 32'hffffffff, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      seed = xs(seed);
      bus(1'h1, {seed[3:2], 2'h1}, seed, seed[7:4]);
      rdc("unmap", {seed[3:2], 2'h1}, 32'hffffffff, 32'h0);
    end
    rdc("ctrl", `TXPIE_CTRL_OFS, 32'hffffffff, 32'h1e1e);
    recenter(4'h3);
    chk("flags", 32'h0, {30'h0, flag});
    data_chk = 1'h1;
    repeat (200) @(posedge clk);
    data_chk = 1'h0;
    host_run = 2'h1;
    repeat (100) @(posedge clk);
    chk("flags", 32'h2, {30'h0, flag});
    rdc("fault", `TXPIE_STAT_OFS, 32'h0202, 32'h0200);
    host_run = 2'h3;
    repeat (100) @(posedge clk);
    chk("flags", 32'h2, {30'h0, flag});
    rdc("int", `TXPIE_INT_STAT_OFS, 32'hffffffff, 32'h10);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'h1, `TXPIE_INT_MASK_OFS, 32'h10, 4'hf);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'h1, `TXPIE_INT_STAT_OFS, 32'h10, 4'hf);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    recenter(4'h2);
    chk("flags", 32'h0, {30'h0, flag});
    cw[0] = 1'h1;
    host_run = 2'h2;
    setc;
    recenter(4'h1);
    repeat (140) @(posedge clk);
    chk("flags", 32'h0, {30'h0, flag});
    cw[0] = 1'h0;
    setc;
    repeat (100) @(posedge clk);
    chk("flags", 32'h1, {30'h0, flag});
    host_run = 2'h3;
    recenter(4'h1);
    cw[3] = 1'h0;
    setc;
    repeat (20) @(posedge clk);
    chk("flags", 32'h0, {30'h0, flag});
    cw[4] = 1'h0;
    setc;
    repeat (20) @(posedge clk);
    chk("flags", 32'h1, {30'h0, flag});
    rdc("pd", `TXPIE_STAT_OFS, 32'h0808, 32'h0008);
    cw[4:3] = 2'h3;
    setc;
    recenter(4'h1);
    cw[2] = 1'h0;
    setc;
    waitf(0, 1'h1, n1);
    waitf(0, 1'h0, n1);
    chk("st_high", 32'h8, n1);
    waitf(0, 1'h1, n2);
    chk("st_per", ST * 8, n1 + n2);
    waitf(0, 1'h0, n1);
    cw[2] = 1'h1;
    setc;
    rdc("int", `TXPIE_INT_STAT_OFS, 32'h4, 32'h4);
    ref_run = 2'h1;
    repeat (RL + 20) @(posedge clk);
    chk("flags", 32'h2, {30'h0, flag});
    rdc("int", `TXPIE_INT_STAT_OFS, 32'h20, 32'h20);
    ref_run = 2'h3;
    repeat (20) @(posedge clk);
    recenter(4'h2);
    chk("flags", 32'h0, {30'h0, flag});
    print_verdict;
  end
endmodule // tb

//--- bench/txpie_checker.sv
// port checker of the tx input/error block
`timescale 1ns/1ps
`include "txpie_regs.vh"
module txpie_checker #(
  parameter NCH      = 2,
  parameter CW       = 10,
  parameter REF_LOSS = 64
) (
  input wire                     core_clk_i,
  input wire                     rst_i,
  input wire [`TXPIE_ADDR_W-1:0] avs_address_i,
  input wire                     avs_read_i,
  input wire                     avs_write_i,
  input wire [31:0]              avs_writedata_i,
  input wire [3:0]               avs_byteenable_i,
  input wire [31:0]              avs_readdata_o,
  input wire                     avs_waitrequest_o,
  input wire                     irq_o,
  input wire [NCH*CW-1:0]        tx_char_in_i,
  input wire [NCH-1:0]           tx_host_char_clock_i,
  input wire [NCH-1:0]           channel_reference_clock_i,
  input wire [NCH-1:0]           tx_error_flag_o,
  input wire [NCH*CW-1:0]        tx_char_out_o,
  input wire [NCH-1:0]           tx_char_strobe_o
);
  reg  [15:0] shadow;
  wire        req  = avs_read_i || avs_write_i;
  wire        done = req && !avs_waitrequest_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // copy of the control bytes as accepted writes leave them
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      shadow <= 16'h1e1e;
    end else if (done && avs_write_i && avs_address_i == `TXPIE_CTRL_OFS) begin
      if (avs_byteenable_i[0]) shadow[7:0] <= avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) shadow[15:8] <= avs_writedata_i[15:8];
    end
  end
  AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  AST_WAIT_TWO: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not in second cycle");
  AST_UNMAPPED: assert property (done && avs_read_i && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(avs_write_i))
    else $error("irq dropped without a write");
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg  [7:0] pd_cnt;
      reg  [7:0] ref_cnt;
      reg        ref_q;
      wire       pd = !shadow[c*8+3] && !shadow[c*8+4];
      wire       st = !shadow[c*8+2];
      wire       f  = tx_error_flag_o[c];
      // cycles spent powered down and since the last reference rise
      always @(posedge core_clk_i) begin
        ref_q <= channel_reference_clock_i[c];
        if (rst_i || !pd) pd_cnt <= 8'h00;
        else if (pd_cnt != 8'hff) pd_cnt <= pd_cnt + 8'h01;
        if (rst_i || (channel_reference_clock_i[c] && !ref_q)) ref_cnt <= 8'h00;
        else if (ref_cnt != 8'hff) ref_cnt <= ref_cnt + 8'h01;
      end
      AST_PD_FLAG: assert property (pd_cnt == 8'h08 |-> f)
        else $error("flag low while powered down");
      AST_REF_LOSS: assert property (ref_cnt == REF_LOSS + 8 |-> f)
        else $error("flag low without reference");
      AST_ST_PULSE: assert property (st && !pd && ref_cnt < 8'h10 && $rose(f)
        |-> f[*7] ##2 !f) else $error("self-test pulse width");
      AST_STROBE_GAP: assert property (tx_char_strobe_o[c]
        |=> !tx_char_strobe_o[c] [*6]) else $error("strobes closer than a reference period");
    end
  endgenerate
  CV_IRQ: cover property ($rose(irq_o));
  CV_ST: cover property (g_ch[0].st && $fell(tx_error_flag_o[0]));
  CV_LOSS: cover property (g_ch[1].ref_cnt == REF_LOSS + 8);
endmodule // txpie_checker

bind txpie_top txpie_checker #(.NCH(NCH), .CW(CW), .REF_LOSS(REF_LOSS)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .tx_char_in_i(tx_char_in_i),
  .tx_host_char_clock_i(tx_host_char_clock_i),
  .channel_reference_clock_i(channel_reference_clock_i),
  .tx_error_flag_o(tx_error_flag_o), .tx_char_out_o(tx_char_out_o),
  .tx_char_strobe_o(tx_char_strobe_o)
);

//--- bench/txpie_host.sv
// host model: per-channel character clock and characters
`timescale 1ns/1ps
module txpie_host #(
  parameter HALF_NS = 80
) (
  input  wire [1:0]  run_i,
  input  wire [9:0]  start_i,
  output reg  [1:0]  host_clk_o,
  output reg  [19:0] chars_o
);
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg [9:0] cnt;
      // stopped clock stands low while the idle data line keeps toggling
      initial begin
        cnt = 10'h000;
        host_clk_o[c] = 1'h0;
        chars_o[c*10+:10] = 10'h000;
        forever begin
          #HALF_NS;
          if (!run_i[c]) begin
            host_clk_o[c] = 1'h0;
            chars_o[c*10+:10] = ~chars_o[c*10+:10];
          end else if (host_clk_o[c]) begin
            host_clk_o[c] = 1'h0;
            cnt = cnt + 10'h001;
            chars_o[c*10+:10] = cnt + start_i;
          end else begin
            host_clk_o[c] = 1'h1;
          end
        end
      end
    end
  endgenerate
endmodule // txpie_host

//--- design/txpie_align.v
// phase-align buffer between capture clock and character clock, with fault detect
`timescale 1ns/1ps
module txpie_align #(
  parameter W  = 10,
  parameter AW = 2
) (
  input  wire          core_clk_i,
  input  wire          rst_i,
  input  wire          recenter_i,
  input  wire          wr_en_i,
  input  wire [W-1:0]  wr_data_i,
  input  wire          rd_en_i,
  output reg  [W-1:0]  rd_data_o,
  output reg           overflow_o,
  output reg           underflow_o,
  output wire [AW:0]   level_o
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam [AW:0] HALF  = {2'b01, {(AW-1){1'b0}}};

  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0]  wr_ptr;
  reg [AW:0]  rd_ptr;
  wire        full  = (level_o == DEPTH);
  wire        empty = (level_o == {(AW+1){1'b0}});
  wire        do_wr = wr_en_i & (~full | rd_en_i);
  wire        do_rd = rd_en_i & (~empty | wr_en_i);

  assign level_o = wr_ptr - rd_ptr;

  // storage
  always @(posedge core_clk_i) begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
  end

  // pointers; re-center puts the writer half a buffer ahead of the reader
  always @(posedge core_clk_i) begin
    if (rst_i || recenter_i) begin
      wr_ptr      <= HALF;
      rd_ptr      <= {(AW+1){1'b0}};
      rd_data_o   <= {W{1'b0}};
      overflow_o  <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      overflow_o  <= wr_en_i & full & ~rd_en_i;
      underflow_o <= rd_en_i & empty & ~wr_en_i;
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) begin
        rd_ptr    <= rd_ptr + 1'b1;
        rd_data_o <= empty ? wr_data_i : mem[rd_ptr[AW-1:0]];
      end
    end
  end
endmodule // txpie_align

//--- design/txpie_sync.v
// two-flop synchroniser with rising-edge detect for pins from outside the core clock
`timescale 1ns/1ps
module txpie_sync #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;
  reg [W-1:0] prev;

  // first flop feeds only the second; edges are found behind the second
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      meta   <= {W{1'b0}};
      stable <= {W{1'b0}};
      prev   <= {W{1'b0}};
    end else begin
      meta   <= async_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~prev;
endmodule // txpie_sync

//--- design/txpie_top.v
// two-channel tx parallel input capture, phase-align buffer and error/status output
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "txpie_regs.vh"
module txpie_top #(
  parameter NCH        = 2,
  parameter CW         = 10,
  parameter AW         = 2,
  parameter REF_LOSS   = `TXPIE_REF_LOSS_CYC,
  parameter ST_LEN     = `TXPIE_SELFTEST_LEN
) (
  input  wire                      core_clk_i,
  input  wire                      rst_i,
  // avalon-mm slave
  input  wire [`TXPIE_ADDR_W-1:0]  avs_address_i,
  input  wire                      avs_read_i,
  input  wire                      avs_write_i,
  input  wire [31:0]               avs_writedata_i,
  input  wire [3:0]                avs_byteenable_i,
  output reg  [31:0]               avs_readdata_o,
  output wire                      avs_waitrequest_o,
  output wire                      irq_o,
  // pins
  input  wire [NCH*CW-1:0]         tx_char_in_i,
  input  wire [NCH-1:0]            tx_host_char_clock_i,
  input  wire [NCH-1:0]            channel_reference_clock_i,
  output reg  [NCH-1:0]            tx_error_flag_o,
  // characters toward the serializer
  output wire [NCH*CW-1:0]         tx_char_out_o,
  output reg  [NCH-1:0]            tx_char_strobe_o
);
  // synchroniser width: characters, host clocks, reference clocks
  localparam SW = NCH*CW + 2*NCH;

  // bus state
  reg  [15:0]     ctrl;
  reg  [7:0]      int_stat;
  reg  [7:0]      int_mask;
  reg             ack;
  wire [31:0]     stat_word;
  wire [7:0]      int_event;
  wire [31:0]     be_mask;
  wire            bus_req;
  wire            wr_take;
  wire            sel_ctrl;
  wire            sel_stat;
  wire            sel_ist;
  wire            sel_imk;

  // synchronised pins
  wire [SW-1:0]   pin_level;
  wire [SW-1:0]   pin_rise;
  wire [NCH*CW-1:0] char_sync;
  wire [NCH-1:0]  host_rise;
  wire [NCH-1:0]  ref_rise;

  // every pin goes through two flops before use
  txpie_sync #(
    .W (SW)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({channel_reference_clock_i, tx_host_char_clock_i, tx_char_in_i}),
    .level_o    (pin_level),
    .rise_o     (pin_rise)
  );

  // split the synchronised word back into its parts
  assign char_sync = pin_level[NCH*CW-1:0];
  assign host_rise = pin_rise[NCH*CW+NCH-1:NCH*CW];
  assign ref_rise  = pin_rise[SW-1:NCH*CW+NCH];

  // avalon decode: one wait cycle, answer on the second edge
  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack;
  assign wr_take           = avs_write_i & ack;

  // register select from the byte address
  assign sel_ctrl          = (avs_address_i == `TXPIE_CTRL_OFS);
  assign sel_stat          = (avs_address_i == `TXPIE_STAT_OFS);
  assign sel_ist           = (avs_address_i == `TXPIE_INT_STAT_OFS);
  assign sel_imk           = (avs_address_i == `TXPIE_INT_MASK_OFS);

  // write data lanes enabled by the byte enables
  assign be_mask           = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                              {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // acknowledge toggles so each request gets exactly one answer edge
  // a held request thus sees waitrequest low at every second edge
  always @(posedge core_clk_i) begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= bus_req & ~ack;
  end

  // read data is loaded on the wait cycle and stands at the answer edge
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack) begin
      if (sel_ctrl)
        avs_readdata_o <= {16'h0000, ctrl};
      else if (sel_stat)
        avs_readdata_o <= stat_word;
      else if (sel_ist)
        avs_readdata_o <= {24'h00_0000, int_stat};
      else if (sel_imk)
        avs_readdata_o <= {24'h00_0000, int_mask};
      else
        avs_readdata_o <= 32'h0000_0000; // unmapped reads as zero
    end
  end

  // configuration latches, byte lanes honoured
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl <= {`TXPIE_CTRL_CH_RST, `TXPIE_CTRL_CH_RST};
    end else if (wr_take && sel_ctrl) begin
      ctrl <= (ctrl & ~be_mask[15:0]) | (avs_writedata_i[15:0] & be_mask[15:0]);
    end
  end

  // interrupt mask
  always @(posedge core_clk_i) begin
    if (rst_i)
      int_mask <= `TXPIE_INT_RST;
    else if (wr_take && sel_imk)
      int_mask <= (int_mask & ~be_mask[7:0]) | (avs_writedata_i[7:0] & be_mask[7:0]);
  end

  // sticky events, write one to clear, a new event wins over the clear
  // so an event in the clearing cycle is never lost
  always @(posedge core_clk_i) begin
    if (rst_i)
      int_stat <= `TXPIE_INT_RST;
    else if (wr_take && sel_ist)
      int_stat <= (int_stat & ~(avs_writedata_i[7:0] & be_mask[7:0])) | int_event;
    else
      int_stat <= int_stat | int_event;
  end

  // level interrupt while any unmasked event is pending
  assign irq_o = |(int_stat & int_mask);

  // per-channel datapath and error reporting
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire            sel_ref;
      wire            st_n;
      wire            oe1;
      wire            oe2;
      wire            recenter;
      wire            cap_edge;
      wire            overflow;
      wire            underflow;
      wire [AW:0]     level;
      wire            synth_pd;
      wire            pass_edge;
      reg             fault;
      reg             ref_absent;
      reg  [15:0]     loss_cnt;
      reg  [8:0]      st_cnt;
      reg             st_pulse;
      reg             fault_d;
      reg             absent_d;
      reg             next_err;

      // this channel's control byte
      assign sel_ref  = ctrl[c*`TXPIE_CH_STRIDE + `TXPIE_CTRL_SEL_BIT];
      assign st_n     = ctrl[c*`TXPIE_CH_STRIDE + `TXPIE_CTRL_STN_BIT];
      assign oe1      = ctrl[c*`TXPIE_CH_STRIDE + `TXPIE_CTRL_OE1_BIT];
      assign oe2      = ctrl[c*`TXPIE_CH_STRIDE + `TXPIE_CTRL_OE2_BIT];

      // a write carrying 0 in this channel's re-center bit starts a re-center
      assign recenter = wr_take & sel_ctrl & avs_byteenable_i[c]
                        & ~avs_writedata_i[c*`TXPIE_CH_STRIDE + `TXPIE_CTRL_RECTR_BIT];

      // capture edge: host char clock when select is 0, else reference clock
      assign cap_edge = sel_ref ? ref_rise[c] : host_rise[c];

      // synthesizer loop is down when both serial outputs are disabled
      assign synth_pd = ~oe1 & ~oe2;

      // characters enter on the capture edge and leave on the reference edge
      txpie_align #(
        .W  (CW),
        .AW (AW)
      ) u_align (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .recenter_i  (recenter),
        .wr_en_i     (cap_edge),
        .wr_data_i   (char_sync[c*CW +: CW]),
        .rd_en_i     (ref_rise[c]),
        .rd_data_o   (tx_char_out_o[c*CW +: CW]),
        .overflow_o  (overflow),
        .underflow_o (underflow),
        .level_o     (level)
      );

      // character strobe follows each read of the buffer
      always @(posedge core_clk_i) begin
        if (rst_i)
          tx_char_strobe_o[c] <= 1'b0;
        else
          tx_char_strobe_o[c] <= ref_rise[c];
      end

      // buffer fault of this channel only, held until re-center
      always @(posedge core_clk_i) begin
        if (rst_i)
          fault <= 1'b0;
        else if (overflow || underflow)
          fault <= 1'b1;
        else if (recenter)
          fault <= 1'b0;
      end

      // reference clock watchdog: no rising edge within the window means absent
      // the window must exceed a reference period or a running clock looks absent
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          loss_cnt   <= 16'h0000;
          ref_absent <= 1'b0;
        end else if (ref_rise[c]) begin
          loss_cnt   <= 16'h0000;
          ref_absent <= 1'b0;
        end else if (loss_cnt >= REF_LOSS[15:0] - 16'h0001) begin
          ref_absent <= 1'b1;
        end else begin
          loss_cnt   <= loss_cnt + 16'h0001;
        end
      end

      // self-test pass counter on the reference clock
      assign pass_edge = ~st_n & ref_rise[c] & (st_cnt == ST_LEN[8:0] - 9'h001);

      // count restarts while self-test is off, so the first pass is a full sequence
      always @(posedge core_clk_i) begin
        if (rst_i || st_n) begin
          st_cnt   <= 9'h000;
          st_pulse <= 1'b0;
        end else if (ref_rise[c]) begin
          if (pass_edge) begin
            st_cnt   <= 9'h000;
            st_pulse <= 1'b1;
          end else begin
            st_cnt   <= st_cnt + 9'h001;
            st_pulse <= 1'b0;
          end
        end
      end

      // error combine
      // power-down and a missing reference still report during self-test
      always @* begin
        next_err = synth_pd | ref_absent;
        if (st_n)
          next_err = next_err | fault;
        else
          next_err = next_err | st_pulse;
      end

      // registered so the pin never glitches between terms
      always @(posedge core_clk_i) begin
        if (rst_i)
          tx_error_flag_o[c] <= 1'b0;
        else
          tx_error_flag_o[c] <= next_err;
      end

      // edge detect of conditions for the interrupt bits
      // only rising edges, so a held condition raises one interrupt
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          fault_d  <= 1'b0;
          absent_d <= 1'b0;
        end else begin
          fault_d  <= fault;
          absent_d <= ref_absent;
        end
      end

      assign int_event[c*`TXPIE_INT_STRIDE + `TXPIE_INT_FAULT_BIT] = fault & ~fault_d;
      assign int_event[c*`TXPIE_INT_STRIDE + `TXPIE_INT_LOSS_BIT]  = ref_absent & ~absent_d;
      assign int_event[c*`TXPIE_INT_STRIDE + `TXPIE_INT_PASS_BIT]  = pass_edge;
      assign int_event[c*`TXPIE_INT_STRIDE + 3]                    = 1'b0;

      // status byte of this channel
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_ERR_BIT]    = tx_error_flag_o[c];
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_FAULT_BIT]  = fault;
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_ABSENT_BIT] = ref_absent;
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_PD_BIT]     = synth_pd;
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_PASS_BIT]   = st_pulse;
      assign stat_word[c*`TXPIE_CH_STRIDE + `TXPIE_ST_LVL_LSB +: AW+1] = level;
    end
  endgenerate

  // unused status bits read as zero
  assign stat_word[31:NCH*`TXPIE_CH_STRIDE] = {(32-NCH*`TXPIE_CH_STRIDE){1'b0}};
endmodule // txpie_top

//--- shared/txpie_regs.vh
// register map, field positions, reset values and timing counts of the tx input/error block
// Overview of operation
// - host presents each 10-bit character for capture on the selected clock's rising edge.
// - per-channel select latch chooses host char clock or reference clock for capture.
// - error output rises on phase-align buffer underflow or overflow.
// - buffer error stays high until software writes the re-center latch.
// - each channel reports only its own buffer errors.
// - self-test enable low makes the error output report self-test progress.
// - self-test pulses error high one character period every 511 character times.
// - error high while both serial output enables are 0, synthesizer down.
// - error high whenever the channel reference clock is absent.
// - select latch 0 uses host char clock to capture parallel data.
// - writing 0 to re-center latch re-initialises the phase-align buffer.
`ifndef TXPIE_REGS_VH
`define TXPIE_REGS_VH

// avalon byte offsets
`define TXPIE_ADDR_W          4
`define TXPIE_CTRL_OFS        4'h0
`define TXPIE_STAT_OFS        4'h4
`define TXPIE_INT_STAT_OFS    4'h8
`define TXPIE_INT_MASK_OFS    4'hc

// control fields, one byte per channel (channel c at bit c*8)
`define TXPIE_CH_STRIDE       8
`define TXPIE_CTRL_SEL_BIT    0
`define TXPIE_CTRL_RECTR_BIT  1
`define TXPIE_CTRL_STN_BIT    2
`define TXPIE_CTRL_OE1_BIT    3
`define TXPIE_CTRL_OE2_BIT    4
`define TXPIE_CTRL_CH_RST     8'h1e

// status fields, one byte per channel
`define TXPIE_ST_ERR_BIT      0
`define TXPIE_ST_FAULT_BIT    1
`define TXPIE_ST_ABSENT_BIT   2
`define TXPIE_ST_PD_BIT       3
`define TXPIE_ST_PASS_BIT     4
`define TXPIE_ST_LVL_LSB      5

// interrupt fields, four bits per channel
`define TXPIE_INT_STRIDE      4
`define TXPIE_INT_FAULT_BIT   0
`define TXPIE_INT_LOSS_BIT    1
`define TXPIE_INT_PASS_BIT    2
`define TXPIE_INT_RST         8'h00

// timing
`define TXPIE_CLK_PERIOD_NS   20
`define TXPIE_REF_LOSS_NS     1280
`define TXPIE_REF_LOSS_CYC    ((`TXPIE_REF_LOSS_NS) / (`TXPIE_CLK_PERIOD_NS))
`define TXPIE_SELFTEST_LEN    511

`endif
